/* File: bench/sls_bus_sender.sv */
// Bus device model that sends group telegrams to the block
`timescale 1ns/1ps
module sls_bus_sender (
	input  wire logic       clock,
	output logic            tg_valid,
	output logic      [1:0] tg_obj,
	output logic      [7:0] tg_data
);
	initial begin
		tg_valid = 1'b0;
		tg_obj   = 2'h0;
		tg_data  = 8'h00;
	end

	// ------------------------------------------------------------
	// Scene value: store flag, reserved zero, number minus one
	// ------------------------------------------------------------
	function automatic logic [7:0] scene_code(input logic store,
		input int num);
		return {store, 1'b0, 6'(num - 1)};
	endfunction : scene_code

	// ------------------------------------------------------------
	// One telegram per call, sent in call order
	// ------------------------------------------------------------
	task automatic send(input logic [1:0] obj, input logic [7:0] data);
		@(posedge clock);
		tg_valid <= 1'b1;
		tg_obj   <= obj;
		tg_data  <= data;
		@(posedge clock);
		tg_valid <= 1'b0;
		tg_obj   <= ~obj;
		tg_data  <= ~data;
	endtask : send
endmodule : sls_bus_sender

/* File: bench/sls_switch_logic_tb_top.sv */
// Testbench for the switch logic and scene block
`timescale 1ns/1ps
module sls_switch_logic_tb_top;
	localparam logic [1:0] O_SW = sls_pkg::OBJ_SWITCH;
	localparam logic [1:0] O_C1 = sls_pkg::OBJ_CONN1;
	localparam logic [1:0] O_C2 = sls_pkg::OBJ_CONN2;
	localparam logic [1:0] O_SC = sls_pkg::OBJ_SCENE;
	localparam logic [3:0] A_CT = sls_pkg::OFS_CTRL;
	localparam logic [3:0] A_ST = sls_pkg::OFS_STATUS;
	localparam logic [3:0] A_S0 = sls_pkg::OFS_SLOT0;

	logic       clock;
	logic       sys_rst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       tg_valid;
	logic [1:0] tg_obj;
	logic [7:0] tg_data;
	logic       bus_reset;
	logic       bus_fail;
	logic       time_in;
	logic       time_in_strobe;
	logic       gate_open;
	logic       sw;
	logic       c1;
	logic       c2;
	int         miscompares;
	int         samples_checked;

	sls_switch_logic dut_u (
		.clock          (clock),
		.sys_rst        (sys_rst),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.tg_valid       (tg_valid),
		.tg_obj         (tg_obj),
		.tg_data        (tg_data),
		.bus_reset      (bus_reset),
		.bus_fail       (bus_fail),
		.time_in        (time_in),
		.time_in_strobe (time_in_strobe),
		.gate_open      (gate_open)
	);

	sls_bus_sender sender_u (
		.clock    (clock),
		.tg_valid (tg_valid),
		.tg_obj   (tg_obj),
		.tg_data  (tg_data)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata & m, exp);
	endtask : rd

	task automatic tg(input logic [1:0] o, input logic [7:0] d,
		input logic st, input logic q);
		sender_u.send(o, d);
		#1;
		check("time_in_strobe", time_in_strobe, st);
		check("time_in", time_in, q);
	endtask : tg

	function automatic logic stage(input logic [1:0] m, input logic a,
		input logic b);
		case (m)
			sls_pkg::MODE_AND: return a & b;
			sls_pkg::MODE_OR:  return a | b;
			default:           return a ^ b;
		endcase
	endfunction : stage

	function automatic logic expd(input logic [1:0] m);
		return stage(m, stage(m, sw, c1), c2);
	endfunction : expd

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_regs();
		rd(A_CT, 8'hFF, sls_pkg::CTRL_RESET);
		rd(A_ST, 8'hFF, 8'h01 << sls_pkg::ST_GATE);
		rd(A_S0, 8'hFF, sls_pkg::SLOT_RESET);
		wr(A_ST, 8'hFF);
		rd(A_ST, 8'hFF, 8'h01 << sls_pkg::ST_GATE);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'hFF, 8'h00);
	endtask : test_regs

	task automatic test_logic();
		logic [1:0] md;
		for (int m = 0; m < 3; m++) begin
			md = 2'(m);
			wr(A_CT, 8'h1C | 8'(md));
			for (int i = 0; i < 8; i++) begin
				c1 = i[1];
				tg(O_C1, 8'(c1), 1'b1, expd(md));
				c2 = i[0];
				tg(O_C2, 8'(c2), 1'b1, expd(md));
				sw = i[2];
				tg(O_SW, 8'(sw), 1'b1, expd(md));
			end
		end
	endtask : test_logic

	task automatic test_unassigned();
		wr(A_CT, 8'h18);
		tg(O_C1, 8'h00, 1'b1, 1'b1);
		tg(O_SW, 8'h00, 1'b1, 1'b0);
		wr(A_CT, 8'h15);
		tg(O_C2, 8'h01, 1'b1, 1'b0);
		tg(O_SW, 8'h01, 1'b1, 1'b1);
		tg(O_SW, 8'h00, 1'b1, 1'b0);
	endtask : test_unassigned

	task automatic test_gate();
		wr(A_CT, 8'h1F);
		tg(O_C1, 8'h01, 1'b0, 1'b0);
		tg(O_C2, 8'h01, 1'b0, 1'b0);
		check("gate_open", gate_open, 1'b1);
		tg(O_SW, 8'h01, 1'b1, 1'b1);
		tg(O_C1, 8'h00, 1'b1, 1'b0);
		check("gate_open", gate_open, 1'b0);
		tg(O_SW, 8'h01, 1'b0, 1'b0);
		tg(O_SW, 8'h00, 1'b0, 1'b0);
		tg(O_C1, 8'h01, 1'b0, 1'b0);
		check("gate_open", gate_open, 1'b1);
		tg(O_SW, 8'h01, 1'b1, 1'b1);
		wr(A_CT, 8'h0F);
		tg(O_C2, 8'h00, 1'b1, 1'b0);
		tg(O_C2, 8'h01, 1'b0, 1'b0);
		check("gate_open", gate_open, 1'b0);
		tg(O_SW, 8'h01, 1'b0, 1'b0);
		wr(A_CT, 8'h1F);
		tg(O_C2, 8'h01, 1'b0, 1'b0);
	endtask : test_gate

	task automatic test_retain();
		wr(A_CT, 8'h1C);
		tg(O_SW, 8'h01, 1'b1, 1'b1);
		tg(O_C2, 8'h00, 1'b1, 1'b0);
		@(posedge clock);
		bus_reset <= 1'b1;
		@(posedge clock);
		bus_reset <= 1'b0;
		#1;
		check("time_in_strobe", time_in_strobe, 1'b1);
		check("time_in", time_in, 1'b0);
		rd(A_ST, 8'h06, 8'h02);
		tg(O_C2, 8'h01, 1'b1, 1'b0);
		tg(O_SW, 8'h01, 1'b1, 1'b1);
		@(posedge clock);
		bus_fail <= 1'b1;
		tg(O_C1, 8'h00, 1'b0, 1'b1);
		rd(A_ST, 8'h26, 8'h26);
		@(posedge clock);
		bus_fail <= 1'b0;
		@(posedge clock);
		#1;
		check("time_in_strobe", time_in_strobe, 1'b1);
		check("time_in", time_in, 1'b1);
		tg(O_SW, 8'h01, 1'b1, 1'b1);
	endtask : test_retain

	task automatic test_scene();
		wr(A_S0, 8'h45);
		wr(A_S0 + 4'h1, 8'hFF);
		wr(A_S0 + 4'h2, 8'h40);
		sender_u.send(O_SC, sender_u.scene_code(1'b1, 6));
		rd(A_S0, 8'hFF, 8'hC5);
		tg(O_SW, 8'h00, 1'b1, 1'b0);
		tg(O_SC, sender_u.scene_code(1'b0, 6), 1'b1, 1'b1);
		tg(O_SC, sender_u.scene_code(1'b0, 1), 1'b1, 1'b0);
		tg(O_SC, sender_u.scene_code(1'b0, 64), 1'b1, 1'b1);
		tg(O_SC, sender_u.scene_code(1'b0, 7), 1'b0, 1'b1);
		tg(O_SC, 8'h40, 1'b0, 1'b1);
	endtask : test_scene

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		miscompares = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		bus_reset = 1'b0;
		bus_fail = 1'b0;
		sw = 1'b0;
		c1 = 1'b0;
		c2 = 1'b0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		test_regs();
		test_logic();
		test_unassigned();
		test_gate();
		test_retain();
		test_scene();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		finish_test();
	end
endmodule : sls_switch_logic_tb_top

/* File: core/sls_scene_table.sv */
// Scene slot table: numbers, enables and stored output values
`timescale 1ns/1ps
module sls_scene_table (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       wr_en,
	input  wire logic [1:0] wr_slot,
	input  wire logic [7:0] wr_data,
	input  wire logic       store_en,
	input  wire logic       store_value,
	input  wire logic [5:0] index,
	input  wire logic [1:0] rd_slot,
	output logic      [7:0] rd_data,
	output logic            hit,
	output logic            hit_value
);
	logic [7:0] slot [sls_pkg::NUM_SLOTS];
	logic [sls_pkg::NUM_SLOTS-1:0] match;

	// ------------------------------------------------------------
	// Match against configured scene numbers
	// ------------------------------------------------------------
	always_comb begin
		hit = 1'b0;
		hit_value = 1'b0;
		for (int i = 0; i < sls_pkg::NUM_SLOTS; i++) begin
			match[i] = slot[i][sls_pkg::SLOT_EN] &&
				(slot[i][5:0] == index);
			if (match[i] && !hit) begin
				hit = 1'b1;
				hit_value = slot[i][sls_pkg::SLOT_VAL];
			end
		end
	end

	assign rd_data = slot[rd_slot];

	// ------------------------------------------------------------
	// Storage; a scene store wins over a software write
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		for (int i = 0; i < sls_pkg::NUM_SLOTS; i++) begin
			if (sys_rst) begin
				slot[i] <= sls_pkg::SLOT_RESET;
			end else if (store_en && match[i]) begin
				slot[i][sls_pkg::SLOT_VAL] <= store_value;
			end else if (wr_en && wr_slot == 2'(i)) begin
				slot[i] <= wr_data;
			end
		end
	end

endmodule : sls_scene_table

/* File: core/sls_switch_logic.sv */
// Switch output logic connection and scene decoding
`timescale 1ns/1ps
module sls_switch_logic (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       tg_valid,
	input  wire logic [1:0] tg_obj,
	input  wire logic [7:0] tg_data,
	input  wire logic       bus_reset,
	input  wire logic       bus_fail,
	output logic            time_in,
	output logic            time_in_strobe,
	output logic            gate_open
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] ctrl;
	logic       sw;
	logic       conn1;
	logic       conn2;
	logic       gate1;
	logic       gate2;
	logic       fail_q;

	// ------------------------------------------------------------
	// One combining stage
	// ------------------------------------------------------------
	function automatic logic stage(
		input logic [1:0] mode,
		input logic       a,
		input logic       b,
		input logic       act
	);
		logic r;
		r = a;
		if (act) begin
			unique case (mode)
				sls_pkg::MODE_AND:  r = a & b;
				sls_pkg::MODE_OR:   r = a | b;
				sls_pkg::MODE_XOR:  r = a ^ b;
				sls_pkg::MODE_GATE: r = a;
			endcase
		end
		return r;
	endfunction : stage

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire [1:0] mode      = ctrl[sls_pkg::CTRL_MODE_LSB +: 2];
	wire       c1_act    = ctrl[sls_pkg::CTRL_C1_ACT];
	wire       c2_act    = ctrl[sls_pkg::CTRL_C2_ACT];
	wire       reopen_en = ctrl[sls_pkg::CTRL_REOPEN];
	wire       gate_mode = mode == sls_pkg::MODE_GATE;

	// Bus reset wins over a telegram in the same cycle
	wire take  = tg_valid && !bus_fail && !bus_reset;
	wire is_sw = take && tg_obj == sls_pkg::OBJ_SWITCH;
	wire is_c1 = take && tg_obj == sls_pkg::OBJ_CONN1;
	wire is_c2 = take && tg_obj == sls_pkg::OBJ_CONN2;
	wire is_sc = take && tg_obj == sls_pkg::OBJ_SCENE
		&& !tg_data[sls_pkg::SCN_RSVD];
	wire [5:0] scn_index = tg_data[5:0];
	wire scn_store = tg_data[sls_pkg::SCN_STORE];

	wire scn_hit;
	wire scn_value;
	wire [7:0] slot_q;

	wire gate_now = (!c1_act || gate1) && (!c2_act || gate2);
	wire recall   = is_sc && !scn_store && scn_hit;
	wire sw_evt   = (is_sw || recall)
		&& (!gate_mode || gate_now);
	wire sw_val   = is_sw ? tg_data[0] : scn_value;

	wire c1_new = is_c1 ? tg_data[0] : conn1;
	wire c2_new = is_c2 ? tg_data[0] : conn2;
	wire sw_new = bus_reset ? 1'b0 : (sw_evt ? sw_val : sw);

	// Two stages in series
	wire comb_out = stage(mode, stage(mode, sw_new, c1_new, c1_act),
		c2_new, c2_act);

	wire recover = fail_q && !bus_fail;
	wire conn_evt = is_c1 || is_c2;
	wire conn_zero = conn_evt && !tg_data[0]
		&& (is_c1 ? c1_act : c2_act);

	// Gate mode: closing forces zero, reopening leaves output alone
	wire gate_upd = sw_evt || conn_zero;
	wire gate_val = conn_zero ? 1'b0 : sw_val;
	wire norm_upd = sw_evt || conn_evt || bus_reset
		|| recover;

	wire next_upd = gate_mode ? gate_upd : norm_upd;
	wire next_out = gate_mode ? gate_val : comb_out;

	wire next_gate1 = is_c1 ? (tg_data[0] ? (gate1 || reopen_en) : 1'b0)
		: gate1;
	wire next_gate2 = is_c2 ? (tg_data[0] ? (gate2 || reopen_en) : 1'b0)
		: gate2;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	wire wr_ctrl = reg_wr && reg_addr == sls_pkg::OFS_CTRL;
	wire [3:0] slot_ofs = reg_addr - sls_pkg::OFS_SLOT0;
	wire in_slots = reg_addr >= sls_pkg::OFS_SLOT0
		&& slot_ofs < 4'(sls_pkg::NUM_SLOTS);
	wire wr_slot = reg_wr && in_slots;

	wire [7:0] status = {2'h0, bus_fail, time_in, gate_now,
		conn2, conn1, sw};
	wire [7:0] next_rdata =
		!reg_rd                          ? 8'h00 :
		reg_addr == sls_pkg::OFS_CTRL   ? ctrl :
		reg_addr == sls_pkg::OFS_STATUS ? status :
		in_slots                         ? slot_q : 8'h00;

	// ------------------------------------------------------------
	// Scene table
	// ------------------------------------------------------------
	sls_scene_table u_scene (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.wr_en      (wr_slot),
		.wr_slot    (slot_ofs[1:0]),
		.wr_data    (reg_wdata),
		.store_en   (is_sc && scn_store),
		.store_value(time_in),
		.index      (scn_index),
		.rd_slot    (slot_ofs[1:0]),
		.rd_data    (slot_q),
		.hit        (scn_hit),
		.hit_value  (scn_value)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl <= sls_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Connection values survive bus reset and bus failure
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			conn1 <= 1'b0;
			conn2 <= 1'b0;
			gate1 <= 1'b1;
			gate2 <= 1'b1;
		end else begin
			conn1 <= c1_new;
			conn2 <= c2_new;
			gate1 <= next_gate1;
			gate2 <= next_gate2;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sw <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			sw <= sw_new;
			fail_q <= bus_fail;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			time_in <= 1'b0;
			time_in_strobe <= 1'b0;
			gate_open <= 1'b1;
		end else begin
			if (next_upd) begin
				time_in <= next_out;
			end
			time_in_strobe <= next_upd;
			gate_open <= (!c1_act || next_gate1)
				&& (!c2_act || next_gate2);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	wire plain_sw = is_sw && !gate_mode;

	property p_two_stage;
		plain_sw |=> time_in == stage($past(mode),
			stage($past(mode), $past(tg_data[0]), $past(conn1),
			$past(c1_act)), $past(conn2), $past(c2_act));
	endproperty
	a_two_stage: assert property (p_two_stage)
		else $error("two stage result wrong");

	property p_and;
		plain_sw && mode == sls_pkg::MODE_AND && c1_act && c2_act
		|=> time_in == ($past(tg_data[0]) && conn1 && conn2);
	endproperty
	a_and: assert property (p_and)
		else $error("and result wrong");

	property p_or;
		plain_sw && mode == sls_pkg::MODE_OR && c1_act && !c2_act
		|=> time_in == ($past(tg_data[0]) || conn1);
	endproperty
	a_or: assert property (p_or)
		else $error("or result wrong");

	property p_xor;
		plain_sw && mode == sls_pkg::MODE_XOR && c1_act && c2_act
		|=> time_in == ($past(tg_data[0]) ^ conn1 ^ conn2);
	endproperty
	a_xor: assert property (p_xor)
		else $error("xor result wrong");

	property p_gate_block;
		is_sw && gate_mode && !gate_now
		|=> !time_in_strobe && $stable(time_in) && $stable(sw);
	endproperty
	a_gate_block: assert property (p_gate_block)
		else $error("switch passed closed gate");

	property p_recompute;
		(is_sw || is_c1 || is_c2) && !gate_mode |=> time_in_strobe;
	endproperty
	a_recompute: assert property (p_recompute)
		else $error("no recompute on object");

	sequence s_close;
		gate_mode && is_c1 && c1_act && !tg_data[0];
	endsequence

	sequence s_reopen;
		gate_mode && is_c1 && c1_act && tg_data[0] && reopen_en;
	endsequence

	property p_close;
		s_close |=> !time_in && time_in_strobe && !gate_open;
	endproperty
	a_close: assert property (p_close)
		else $error("gate close not forcing zero");

	property p_reopen;
		s_reopen |=> !time_in_strobe && $stable(time_in);
	endproperty
	a_reopen: assert property (p_reopen)
		else $error("reopen changed output");

	property p_gate_quiet;
		gate_mode && !sw_evt && !conn_zero |=> !time_in_strobe;
	endproperty
	a_gate_quiet: assert property (p_gate_quiet)
		else $error("gate output changed without switch");

	property p_fail_keep;
		bus_fail || bus_reset |=> $stable(conn1) && $stable(conn2);
	endproperty
	a_fail_keep: assert property (p_fail_keep)
		else $error("connection changed on fail or reset");

	property p_unassigned;
		is_c1 && !c1_act && !gate_mode
		|=> time_in == stage($past(mode), $past(sw), $past(conn2),
			$past(c2_act));
	endproperty
	a_unassigned: assert property (p_unassigned)
		else $error("unassigned connection used");

	property p_scene_miss;
		is_sc && !scn_hit && !gate_mode && !recover
		|=> !time_in_strobe;
	endproperty
	a_scene_miss: assert property (p_scene_miss)
		else $error("scene acted without match");

	property p_recall;
		recall && !gate_mode |=> time_in_strobe
			&& time_in == stage($past(mode), stage($past(mode),
			$past(scn_value), $past(conn1), $past(c1_act)),
			$past(conn2), $past(c2_act));
	endproperty
	a_recall: assert property (p_recall)
		else $error("scene recall value wrong");

	property p_bus_reset;
		bus_reset && !gate_mode |=> time_in_strobe && !sw;
	endproperty
	a_bus_reset: assert property (p_bus_reset)
		else $error("bus reset did not recompute");

	property p_fail_drop;
		bus_fail && !bus_reset |=> !time_in_strobe && $stable(sw);
	endproperty
	a_fail_drop: assert property (p_fail_drop)
		else $error("telegram taken during bus failure");

	property p_restore;
		fail_q && !bus_fail && !gate_mode |=> time_in_strobe;
	endproperty
	a_restore: assert property (p_restore)
		else $error("no recompute on bus recovery");

endmodule : sls_switch_logic

/* File: inc/sls_pkg.sv */
// Constants for the switch logic and scene block
package sls_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_SLOT0  = 4'h2;
	localparam int         NUM_SLOTS  = 4;

	// ------------------------------------------------------------
	// Control fields and reset value
	// ------------------------------------------------------------
	localparam int         CTRL_MODE_LSB = 0;
	localparam int         CTRL_C1_ACT   = 2;
	localparam int         CTRL_C2_ACT   = 3;
	localparam int         CTRL_REOPEN   = 4;
	localparam logic [7:0] CTRL_RESET    = 8'h1C;

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	localparam int ST_SWITCH = 0;
	localparam int ST_CONN1  = 1;
	localparam int ST_CONN2  = 2;
	localparam int ST_GATE   = 3;
	localparam int ST_OUT    = 4;
	localparam int ST_FAIL   = 5;

	// ------------------------------------------------------------
	// Scene slot fields and telegram layout
	// ------------------------------------------------------------
	localparam int         SLOT_EN      = 6;
	localparam int         SLOT_VAL     = 7;
	localparam logic [7:0] SLOT_RESET   = 8'h00;
	localparam int         SCN_STORE    = 7;
	localparam int         SCN_RSVD     = 6;

	// ------------------------------------------------------------
	// Logic modes and telegram objects
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_AND  = 2'h0;
	localparam logic [1:0] MODE_OR   = 2'h1;
	localparam logic [1:0] MODE_XOR  = 2'h2;
	localparam logic [1:0] MODE_GATE = 2'h3;

	localparam logic [1:0] OBJ_SWITCH = 2'h0;
	localparam logic [1:0] OBJ_CONN1  = 2'h1;
	localparam logic [1:0] OBJ_CONN2  = 2'h2;
	localparam logic [1:0] OBJ_SCENE  = 2'h3;

endpackage : sls_pkg
